// ==== pet_pkg.sv ====
// Constants shared by the prescaled eight-bit timer.
package pet_pkg;
	// Data width of the APB bus.
	localparam int PET_APB_DW = 32;
	// Address width decoded by the slave.
	localparam int PET_APB_AW = 8;
	// Byte offsets of the registers.
	localparam logic [7:0] PET_OFS_OPTION = 8'h00;
	localparam logic [7:0] PET_OFS_COUNT  = 8'h04;
	localparam logic [7:0] PET_OFS_STATUS = 8'h08;
	localparam logic [7:0] PET_OFS_CLEAR  = 8'h0C;
	localparam logic [7:0] PET_OFS_ENABLE = 8'h10;
	// Field positions inside the option register.
	localparam int PET_POS_SRC  = 5;
	localparam int PET_POS_EDGE = 4;
	localparam int PET_POS_PSA  = 3;
	localparam int PET_POS_RATE = 0;
	// Width of the rate code and of the stored option bits.
	localparam int PET_RATE_W = 3;
	localparam int PET_OPT_W  = 6;
	// Bit of the rollover flag in status, clear and enable.
	localparam int PET_POS_ROLL = 0;
	// Reset values.
	localparam logic [5:0] PET_RST_OPTION = 6'h00;
	localparam logic [7:0] PET_RST_COUNT  = 8'h00;
	localparam logic [7:0] PET_RST_PSCNT  = 8'h00;
	localparam logic       PET_RST_ENABLE = 1'h0;
	// Largest count value before wrapping.
	localparam logic [7:0] PET_COUNT_MAX  = 8'hFF;
	// Count source encodings.
	typedef enum logic [0:0] {
		PET_SRC_INSTR = 1'b0,
		PET_SRC_EXT   = 1'b1
	} pet_src_t;
	// Prescaler assignment encodings.
	typedef enum logic [0:0] {
		PET_PSA_TIMER  = 1'b0,
		PET_PSA_BYPASS = 1'b1
	} pet_psa_t;
endpackage

// ==== pet_timer.sv ====
// Eight-bit timer with prescaler, external event input and APB registers.
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
module pet_timer
	import pet_pkg::*;
#(
	parameter int CNT_W = 8
)
(
	// Clock and synchronous reset.
	input  wire logic                  sys_clk,
	input  wire logic                  nrst,
	// APB slave.
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [PET_APB_AW-1:0] paddr,
	input  wire logic [PET_APB_DW-1:0] pwdata,
	output logic      [PET_APB_DW-1:0] prdata,
	output logic                       pready,
	output logic                       pslverr,
	// External event pin.
	input  wire logic                  eventIn,
	// Interrupt.
	output logic                       irq
);

	// A mask rather than a compare lets the prescaler run freely, so a change
	// of rate never strands its count above the terminal value.
	// Division mask: the prescaler output fires when the low bits are all one.
	function automatic logic [7:0] rateMask(input logic [PET_RATE_W-1:0] rate);
		logic [8:0] ratio;
		ratio = 9'h002 << rate;
		return 8'(ratio - 9'h001);
	endfunction

	// True when the address names a mapped register.
	function automatic logic isMapped(input logic [PET_APB_AW-1:0] a);
		return (a == PET_OFS_OPTION) || (a == PET_OFS_COUNT) ||
			(a == PET_OFS_STATUS) || (a == PET_OFS_CLEAR) ||
			(a == PET_OFS_ENABLE);
	endfunction

	// Stored option bits 5:0; bits 7:6 are not kept.
	logic [PET_OPT_W-1:0]  option_ff;
	// Timer count value.
	logic [CNT_W-1:0]      count_ff;
	// Hidden prescaler count.
	logic [7:0]            psCnt_ff;
	// Sticky rollover flag and its enable.
	logic                  rollFlag_ff;
	logic                  rollEn_ff;
	// Read data latched in the setup cycle.
	logic [PET_APB_DW-1:0] rdata_ff;
	// Event pin synchroniser and filtered level.
	logic                  evtS1_ff;
	logic                  evtS2_ff;
	logic                  evtS3_ff;
	logic                  evtLvl_ff;
	logic                  evtPrev_ff;

	// Decoded option fields.
	pet_src_t              srcSel;
	logic                  edgeSel;
	pet_psa_t              psAssign;
	logic [PET_RATE_W-1:0] rateCode;
	// Bus strobes.
	logic                  apbSetup;
	logic                  apbAccess;
	logic                  wrStb;
	logic                  wrCount;
	logic                  wrClear;
	// Counting path.
	logic                  extEdge;
	logic                  srcTick;
	logic                  psPulse;
	logic                  incEn;
	logic                  rollEvt;

	// Field extraction from the option register.
	assign srcSel   = pet_src_t'(option_ff[PET_POS_SRC]);
	assign edgeSel  = option_ff[PET_POS_EDGE];
	assign psAssign = pet_psa_t'(option_ff[PET_POS_PSA]);
	assign rateCode = option_ff[PET_POS_RATE +: PET_RATE_W];

	// The slave answers with no wait state; read data is set up a cycle early.
	assign pready    = 1'b1;
	assign apbSetup  = psel && !penable;
	assign apbAccess = psel && penable;
	assign pslverr   = apbAccess && !isMapped(paddr);
	assign wrStb     = apbAccess && pready && pwrite;
	assign wrCount   = wrStb && (paddr == PET_OFS_COUNT);
	assign wrClear   = wrStb && (paddr == PET_OFS_CLEAR);
	assign prdata    = rdata_ff;

	// Three-stage synchroniser on the event pin.
	// The first stage may go metastable, so only the second stage reads it.
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			evtS1_ff <= 1'b0;
			evtS2_ff <= 1'b0;
			evtS3_ff <= 1'b0;
		end
		else
		begin
			evtS1_ff <= eventIn;
			evtS2_ff <= evtS1_ff;
			evtS3_ff <= evtS2_ff;
		end
	end

	// The level only changes once the last two stages agree, which rejects
	// a single-cycle glitch at the cost of one more cycle of latency.
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			evtLvl_ff  <= 1'b0;
			evtPrev_ff <= 1'b0;
		end
		else
		begin
			if (evtS2_ff == evtS3_ff)
			begin
				evtLvl_ff <= evtS2_ff;
			end
			evtPrev_ff <= evtLvl_ff;
		end
	end

	// Edge select: zero counts rising edges, one counts falling edges.
	assign extEdge = edgeSel ? (evtPrev_ff && !evtLvl_ff) : (!evtPrev_ff && evtLvl_ff);

	// Source mux; the edge setting only matters on the external path.
	assign srcTick = (srcSel == PET_SRC_INSTR) ? 1'b1 : extEdge;

	// Prescaler output fires every 2 to 256 source ticks.
	assign psPulse = srcTick && ((psCnt_ff & rateMask(rateCode)) == rateMask(rateCode));

	// Counter advance, through the prescaler or straight from the source.
	assign incEn = (psAssign == PET_PSA_TIMER) ? psPulse : srcTick;

	// A software write wins over a coincident increment, so no rollover then.
	assign rollEvt = incEn && !wrCount && (count_ff == CNT_W'(PET_COUNT_MAX));

	// Prescaler count; not mapped anywhere, cleared by a count write.
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			psCnt_ff <= PET_RST_PSCNT;
		end
		else if (wrCount)
		begin
			psCnt_ff <= PET_RST_PSCNT;
		end
		else if (psAssign == PET_PSA_BYPASS)
		begin
			// Held at zero while bypassed so it restarts cleanly.
			psCnt_ff <= PET_RST_PSCNT;
		end
		else if (srcTick)
		begin
			psCnt_ff <= psCnt_ff + 8'h01;
		end
	end

	// Timer count: loaded by software, else advanced and wrapped.
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			count_ff <= CNT_W'(PET_RST_COUNT);
		end
		else if (wrCount)
		begin
			count_ff <= pwdata[CNT_W-1:0];
		end
		else if (incEn)
		begin
			count_ff <= count_ff + CNT_W'(1);
		end
	end

	// Option register write.
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			option_ff <= PET_RST_OPTION;
		end
		else if (wrStb && (paddr == PET_OFS_OPTION))
		begin
			option_ff <= pwdata[PET_OPT_W-1:0];
		end
	end

	// Rollover flag: a new event in the clearing cycle keeps it set.
	// Software clears it by writing one to the clear register, never the status.
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			rollFlag_ff <= 1'b0;
		end
		else
		begin
			rollFlag_ff <= rollEvt || (rollFlag_ff && !(wrClear && pwdata[PET_POS_ROLL]));
		end
	end

	// Interrupt enable register.
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			rollEn_ff <= PET_RST_ENABLE;
		end
		else if (wrStb && (paddr == PET_OFS_ENABLE))
		begin
			rollEn_ff <= pwdata[PET_POS_ROLL];
		end
	end

	// Level interrupt while an enabled flag is set.
	assign irq = rollFlag_ff && rollEn_ff;

	// Read data is captured in the setup cycle so the access phase
	// can finish at once; the clear register reads as zero.
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			rdata_ff <= '0;
		end
		else if (apbSetup && !pwrite)
		begin
			case (paddr)
				PET_OFS_OPTION: rdata_ff <= {{(PET_APB_DW-PET_OPT_W){1'b0}}, option_ff};
				PET_OFS_COUNT:  rdata_ff <= {{(PET_APB_DW-CNT_W){1'b0}}, count_ff};
				PET_OFS_STATUS: rdata_ff <= {{(PET_APB_DW-1){1'b0}}, rollFlag_ff};
				PET_OFS_ENABLE: rdata_ff <= {{(PET_APB_DW-1){1'b0}}, rollEn_ff};
				default:        rdata_ff <= '0;
			endcase
		end
	end

	// Checks on the counting path and the flag.
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	// A write to the count loads it and restarts the prescaler.
	sequence s_countWrite;
		wrCount;
	endsequence
	property p_countLoad;
		s_countWrite |=> (count_ff == $past(pwdata[CNT_W-1:0])) && (psCnt_ff == 8'h00);
	endproperty
	a_countLoad: assert property (p_countLoad) else $error("count write not loaded");

	// Wrap from the maximum lands on zero.
	property p_wrap;
		rollEvt |=> (count_ff == CNT_W'(0));
	endproperty
	a_wrap: assert property (p_wrap) else $error("count did not wrap to zero");

	// Rollover raises the flag on the next edge.
	property p_flagSet;
		rollEvt |=> rollFlag_ff;
	endproperty
	a_flagSet: assert property (p_flagSet) else $error("rollover flag not set");

	// Without a clearing write the flag never falls.
	property p_flagHold;
		rollFlag_ff && !wrClear |=> rollFlag_ff;
	endproperty
	a_flagHold: assert property (p_flagHold) else $error("rollover flag fell on its own");

	// A clearing write with no new rollover drops the flag.
	property p_flagClear;
		wrClear && pwdata[PET_POS_ROLL] && !rollEvt |=> !rollFlag_ff;
	endproperty
	a_flagClear: assert property (p_flagClear) else $error("rollover flag not cleared");

	// Instruction source and bypass: count steps every cycle, any edge setting.
	property p_bypassStep;
		(srcSel == PET_SRC_INSTR) && (psAssign == PET_PSA_BYPASS) && !wrCount
			##1 !wrCount && $stable(option_ff)
			|-> count_ff == $past(count_ff) + CNT_W'(1);
	endproperty
	a_bypassStep: assert property (p_bypassStep) else $error("bypass count did not step");

	// Divide by two with the instruction clock: steps on alternate cycles.
	sequence s_divTwo;
		(option_ff == 6'h00) && !wrCount && (psCnt_ff == 8'h00);
	endsequence
	property p_divTwo;
		s_divTwo ##1 (option_ff == 6'h00) && !wrCount [*2]
			|-> count_ff == $past(count_ff, 2) + CNT_W'(1);
	endproperty
	a_divTwo: assert property (p_divTwo) else $error("prescale by two wrong");

	// Rate 111 lets the counter step only when the prescaler is full.
	property p_rate256;
		incEn && (psAssign == PET_PSA_TIMER) && (rateCode == 3'h7) |-> psCnt_ff == 8'hFF;
	endproperty
	a_rate256: assert property (p_rate256) else $error("rate 111 stepped early");

	// External source without an edge never advances the count.
	property p_extQuiet;
		(srcSel == PET_SRC_EXT) && !extEdge && !wrCount |=> $stable(count_ff);
	endproperty
	a_extQuiet: assert property (p_extQuiet) else $error("count moved without event");

	// Option bits 7:6 always read back as zero.
	property p_optRead;
		apbSetup && !pwrite && (paddr == PET_OFS_OPTION) |=> rdata_ff[7:6] == 2'h0;
	endproperty
	a_optRead: assert property (p_optRead) else $error("unused option bits read nonzero");

	// An enabled rollover raises the interrupt line on the next edge.
	property p_irq;
		rollEvt && rollEn_ff && !(wrStb && (paddr == PET_OFS_ENABLE)) |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt level wrong");

endmodule

// ==== pet_event_src.sv ====
// Model of the external event pin in front of the timer.
`timescale 1ns/1ps
module pet_event_src
(
	// Clock that paces pin changes.
	input  wire logic sys_clk,
	// Pin level toward the timer.
	output logic      eventIn
);
	// The pin idles low between events.
	initial eventIn = 1'b0;
	// Sets a level and holds it so the synchroniser and filter can settle.
	task automatic level(input logic v, input int hold);
		eventIn <= v;
		repeat (hold) @(posedge sys_clk);
	endtask
	// Whole pulses; each phase is wider than the filter needs.
	task automatic pulse(input int n);
		repeat (n)
		begin
			level(1'b1, 8);
			level(1'b0, 8);
		end
	endtask
endmodule

// ==== test_prescaled_eight_bit_timer.sv ====
// Self-checking bench for the prescaled eight-bit timer.
`timescale 1ns/1ps
module test_prescaled_eight_bit_timer
	import pet_pkg::*;
;
	// Clock, reset and APB signals.
	logic                  sys_clk;
	logic                  nrst;
	logic                  psel;
	logic                  penable;
	logic                  pwrite;
	logic [PET_APB_AW-1:0] paddr;
	logic [PET_APB_DW-1:0] pwdata;
	logic [PET_APB_DW-1:0] prdata;
	logic                  pready;
	logic                  pslverr;
	logic                  eventIn;
	logic                  irq;
	// Counters and the last bus answer.
	int                    failures;
	int                    cmp_count;
	logic [31:0]           rd;
	logic                  err;

	pet_timer #(.CNT_W(8)) u_dut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .eventIn(eventIn), .irq(irq));
	pet_event_src u_src (.sys_clk(sys_clk), .eventIn(eventIn));

	// Free-running 25 MHz clock.
	always #20 sys_clk = ~sys_clk;

	// Compares one value and reports a mismatch at once.
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One APB transfer; only the watchdog ends a wait for a dead slave.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1)
			@(posedge sys_clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	// Reads a register and compares it.
	task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(name, exp, rd);
	endtask

	// Writes the count, lets m cycles pass, then reads it back.
	// The read samples the count after m+1 ticks past the write.
	task automatic cnt_after(input logic [7:0] n0, input int m, input logic [31:0] exp);
		apb(1'b1, PET_OFS_COUNT, {24'h0, n0});
		repeat (m) @(posedge sys_clk);
		rdchk("count", PET_OFS_COUNT, exp);
	endtask

	// Reset values, unmapped access and option layout.
	task automatic t_regs();
		rdchk("option", PET_OFS_OPTION, 32'h0);
		rdchk("status", PET_OFS_STATUS, 32'h0);
		rdchk("enable", PET_OFS_ENABLE, 32'h0);
		rdchk("clear", PET_OFS_CLEAR, 32'h0);
		rdchk("unmapped", 8'h14, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		apb(1'b1, PET_OFS_OPTION, 32'hFF);
		rdchk("option", PET_OFS_OPTION, 32'h3F);
	endtask

	// Every rate code at both sides of its second step; odd codes set the edge bit.
	task automatic t_rates();
		int div;
		for (int r = 0; r < 8; r++)
		begin
			div = 2 << r;
			apb(1'b1, PET_OFS_OPTION, r | ((r % 2) << 4));
			cnt_after(8'h10, 2 * div - 2, 32'h11);
			cnt_after(8'h10, 2 * div - 1, 32'h12);
		end
		apb(1'b1, PET_OFS_OPTION, 32'h08);
		cnt_after(8'h20, 5, 32'h26);
		cnt_after(8'hFD, 3, 32'h01);
	endtask

	// Rollover sets a sticky flag; enable masks the line; clear drops it.
	task automatic t_irq();
		apb(1'b1, PET_OFS_ENABLE, 32'h1);
		apb(1'b1, PET_OFS_CLEAR, 32'h1);
		chk("irq", 32'h0, {31'h0, irq});
		apb(1'b1, PET_OFS_COUNT, 32'hFE);
		repeat (3) @(posedge sys_clk);
		chk("irq", 32'h1, {31'h0, irq});
		apb(1'b1, PET_OFS_OPTION, 32'h28);
		repeat (300) @(posedge sys_clk);
		rdchk("status", PET_OFS_STATUS, 32'h1);
		apb(1'b1, PET_OFS_ENABLE, 32'h0);
		chk("irq", 32'h0, {31'h0, irq});
		apb(1'b1, PET_OFS_ENABLE, 32'h1);
		chk("irq", 32'h1, {31'h0, irq});
		apb(1'b1, PET_OFS_CLEAR, 32'h1);
		chk("irq", 32'h0, {31'h0, irq});
		rdchk("status", PET_OFS_STATUS, 32'h0);
	endtask

	// External events: rising, falling and prescaled.
	task automatic t_ext();
		apb(1'b1, PET_OFS_COUNT, 32'h0);
		u_src.level(1'b1, 10);
		rdchk("count", PET_OFS_COUNT, 32'h1);
		u_src.level(1'b0, 10);
		rdchk("count", PET_OFS_COUNT, 32'h1);
		apb(1'b1, PET_OFS_OPTION, 32'h38);
		apb(1'b1, PET_OFS_COUNT, 32'h0);
		u_src.level(1'b1, 10);
		rdchk("count", PET_OFS_COUNT, 32'h0);
		u_src.level(1'b0, 10);
		rdchk("count", PET_OFS_COUNT, 32'h1);
		apb(1'b1, PET_OFS_OPTION, 32'h20);
		apb(1'b1, PET_OFS_COUNT, 32'h0);
		u_src.pulse(4);
		rdchk("count", PET_OFS_COUNT, 32'h2);
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic wrap_up();
		$display("Comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Cuts a hang short, well beyond the few thousand cycles the tests need.
	initial
	begin
		repeat (50000) @(posedge sys_clk);
		failures++;
		wrap_up();
	end

	// Main sequence.
	initial
	begin
		sys_clk = 1'b0;
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		failures = 0;
		cmp_count = 0;
		repeat (20) @(posedge sys_clk);
		nrst <= 1'b1;
		t_regs();
		t_rates();
		t_irq();
		t_ext();
		wrap_up();
	end
endmodule
